/* File: hw/pgs_defines.svh */
// register offsets, field positions, reset values and limits of the pattern generator block
`ifndef PGS_DEFINES_SVH
`define PGS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PGS_ADDR_GEN_CTRL   8'h52
`define PGS_ADDR_RESERVED_WORD_53_53    8'h53
`define PGS_ADDR_TIME_UPPER 8'h54
`define PGS_ADDR_TIME_LOWER 8'h55
`define PGS_ADDR_THRESHOLD  8'h56
`define PGS_ADDR_EYE_CFG    8'h57

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PGS_RST_GEN_CTRL    10'h106
`define PGS_RST_TIME_UPPER  16'h0000
`define PGS_RST_TIME_LOWER  16'h0064
`define PGS_RST_THRESHOLD   16'h0064
`define PGS_RST_EYE_INIT    1'h0

// ----------------------------------------------------------------
// field positions of pattern_generator_control and eye config
// ----------------------------------------------------------------
`define PGS_CTRL_W          10
`define PGS_BIT_ON          9
`define PGS_BIT_SELECT      8
`define PGS_SRC_HI          7
`define PGS_SRC_LO          6
`define PGS_DIV_HI          5
`define PGS_DIV_LO          4
`define PGS_BIT_INVERT      3
`define PGS_RATE_HI         2
`define PGS_RATE_LO         0
`define PGS_BIT_EYE_INIT    2

// ----------------------------------------------------------------
// scan time valid ranges, in microseconds
// ----------------------------------------------------------------
`define PGS_TIME_R1_LO      32'h0000_0001
`define PGS_TIME_R1_HI      32'h0000_199b
`define PGS_TIME_R2_LO      32'h0001_0000
`define PGS_TIME_R2_HI      32'h0001_99bf
`define PGS_TIME_R3_LO      32'h0002_0000
`define PGS_TIME_R3_HI      32'h0033_1df0

`endif

/* File: hw/pgs_gen_ctrl.sv */
// pattern generator control and eye-scan settings, reached by the register port
`timescale 1ns/1ps
`include "pgs_defines.svh"

module pgs_gen_ctrl
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // recovered clock and cdr state
    input  wire logic        cdr_clk_i,
    input  wire logic [2:0]  cdr_rate_i,
    input  wire logic        cdr_locked_i,
    // automatic output modes
    input  wire logic        auto_sleep_i,
    input  wire logic        auto_mute_i,
    input  wire logic        auto_disable_i,
    // serial output
    output logic             ser_data_o,
    output logic             ser_drive_en_o,
    output logic             gen_active_o,
    output logic      [2:0]  gen_rate_o,
    output logic             rate_conflict_o,
    // eye scan settings and point results
    input  wire logic        point_done_i,
    input  wire logic [15:0] point_err_count_i,
    output logic      [31:0] scan_time_us_o,
    output logic      [32:0] point_window_us_o,
    output logic             scan_time_valid_o,
    output logic      [15:0] point_error_threshold_o,
    output logic             eye_init_o,
    output logic             point_good_o,
    output logic             point_result_valid_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [`PGS_CTRL_W-1:0] ctrl_reg;
    logic [15:0]            time_upper_reg;
    logic [15:0]            time_lower_reg;
    logic [15:0]            threshold_reg;
    logic                   eye_init_reg;
    logic [15:0]            rdata_next;
    logic                   pattern_gen_on;
    logic                   pattern_or_clock_select;
    pgs_pkg::pgs_clk_src_t  pattern_clock_source;
    logic [1:0]             pattern_clock_divide_ratio;
    logic                   pattern_invert;
    logic [2:0]             pattern_rate_code;
    logic [2:0]             eff_rate;
    logic                   src_legal;
    logic                   rate_legal;
    logic                   conflict;
    logic                   run;
    logic                   cdr_sync1_reg;
    logic                   cdr_sync2_reg;
    logic                   cdr_prev_reg;
    logic [5:0]             presc_reg;
    logic [5:0]             presc_limit;
    logic                   step_reg;
    logic [3:0]             div_cnt_reg;
    logic [3:0]             div_limit;
    logic                   div_clk_reg;
    logic                   prbs_bit;
    logic                   data_next;
    logic [31:0]            scan_time;

    assign pattern_gen_on             = ctrl_reg[`PGS_BIT_ON];
    assign pattern_or_clock_select    = ctrl_reg[`PGS_BIT_SELECT];
    assign pattern_clock_source       = pgs_pkg::pgs_clk_src_t'(ctrl_reg[`PGS_SRC_HI:`PGS_SRC_LO]);
    assign pattern_clock_divide_ratio = ctrl_reg[`PGS_DIV_HI:`PGS_DIV_LO];
    assign pattern_invert             = ctrl_reg[`PGS_BIT_INVERT];
    assign pattern_rate_code          = ctrl_reg[`PGS_RATE_HI:`PGS_RATE_LO];
    assign scan_time                  = {time_upper_reg, time_lower_reg};

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg       <= `PGS_RST_GEN_CTRL;
            time_upper_reg <= `PGS_RST_TIME_UPPER;
            time_lower_reg <= `PGS_RST_TIME_LOWER;
            threshold_reg  <= `PGS_RST_THRESHOLD;
            eye_init_reg   <= `PGS_RST_EYE_INIT;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                `PGS_ADDR_GEN_CTRL:   ctrl_reg       <= reg_wdata_i[`PGS_CTRL_W-1:0];
                `PGS_ADDR_TIME_UPPER: time_upper_reg <= reg_wdata_i;
                `PGS_ADDR_TIME_LOWER: time_lower_reg <= reg_wdata_i;
                `PGS_ADDR_THRESHOLD:  threshold_reg  <= reg_wdata_i;
                `PGS_ADDR_EYE_CFG:    eye_init_reg   <= reg_wdata_i[`PGS_BIT_EYE_INIT];
                default:              ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register reads: one cycle later, unmapped and reserved read zero
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_next = 16'h0000;
        unique case (reg_addr_i)
            `PGS_ADDR_GEN_CTRL:   rdata_next = {6'h00, ctrl_reg};
            `PGS_ADDR_TIME_UPPER: rdata_next = time_upper_reg;
            `PGS_ADDR_TIME_LOWER: rdata_next = time_lower_reg;
            `PGS_ADDR_THRESHOLD:  rdata_next = threshold_reg;
            `PGS_ADDR_EYE_CFG:    rdata_next = {13'h0000, eye_init_reg, 2'h0};
            default:              rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rdata_o  <= reg_rd_i ? rdata_next : 16'h0000;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // ----------------------------------------------------------------
    // run decision and effective rate
    // ----------------------------------------------------------------
    assign src_legal  = (pattern_clock_source == pgs_pkg::PGS_SRC_VCO)
                     || (pattern_clock_source == pgs_pkg::PGS_SRC_CDR);
    assign eff_rate   = (pattern_clock_source == pgs_pkg::PGS_SRC_CDR)
                      ? cdr_rate_i : pattern_rate_code;
    assign rate_legal = (eff_rate != pgs_pkg::PGS_RATE_RSV0)
                     && (eff_rate != pgs_pkg::PGS_RATE_RSV7);
    // a locked link forbids any generator rate but its own
    assign conflict   = pattern_gen_on && cdr_locked_i
                     && (pattern_clock_source == pgs_pkg::PGS_SRC_VCO)
                     && (pattern_rate_code != cdr_rate_i);
    assign run        = pattern_gen_on && src_legal && rate_legal && !conflict;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gen_active_o    <= 1'b0;
            gen_rate_o      <= pgs_pkg::PGS_RATE_12G;
            rate_conflict_o <= 1'b0;
        end
        else
        begin
            gen_active_o    <= run;
            gen_rate_o      <= eff_rate;
            rate_conflict_o <= conflict;
        end
    end

    // ----------------------------------------------------------------
    // bit steps: vco prescaler or recovered clock edges
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cdr_sync1_reg <= 1'b0;
            cdr_sync2_reg <= 1'b0;
            cdr_prev_reg  <= 1'b0;
        end
        else
        begin
            cdr_sync1_reg <= cdr_clk_i;
            cdr_sync2_reg <= cdr_sync1_reg;
            cdr_prev_reg  <= cdr_sync2_reg;
        end
    end

    // slower rates step less often: 12g every cycle, madi every 32nd
    assign presc_limit = 6'((7'h01 << (pgs_pkg::PGS_RATE_12G - pattern_rate_code)) - 7'h01);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run)
        begin
            presc_reg <= 6'h00;
            step_reg  <= 1'b0;
        end
        else if (pattern_clock_source == pgs_pkg::PGS_SRC_CDR)
        begin
            presc_reg <= 6'h00;
            step_reg  <= cdr_sync2_reg && !cdr_prev_reg;
        end
        else
        begin
            step_reg  <= (presc_reg >= presc_limit);
            presc_reg <= (presc_reg >= presc_limit) ? 6'h00 : presc_reg + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // clock divider and pattern source
    // ----------------------------------------------------------------
    assign div_limit = 4'((5'h01 << pattern_clock_divide_ratio) - 5'h01);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run)
        begin
            div_cnt_reg <= 4'h0;
            div_clk_reg <= 1'b0;
        end
        else if (step_reg)
        begin
            if (div_cnt_reg >= div_limit)
            begin
                div_cnt_reg <= 4'h0;
                div_clk_reg <= !div_clk_reg;
            end
            else
            begin
                div_cnt_reg <= div_cnt_reg + 4'h1;
            end
        end
    end

    pgs_lfsr
    #(
        .WIDTH (7),
        .TAP_A (7),
        .TAP_B (6),
        .SEED  (7'h7f)
    )
    u_prbs7
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .step_i (step_reg && run),
        .bit_o  (prbs_bit)
    );

    // ----------------------------------------------------------------
    // serial output: auto modes keep priority over the generator
    // ----------------------------------------------------------------
    always_comb
    begin
        data_next = 1'b0;
        if (run && !auto_mute_i)
        begin
            data_next = pattern_or_clock_select ? (prbs_bit ^ pattern_invert)
                                                : div_clk_reg;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ser_data_o     <= 1'b0;
            ser_drive_en_o <= 1'b0;
        end
        else
        begin
            ser_data_o     <= data_next;
            ser_drive_en_o <= !(auto_sleep_i || auto_disable_i);
        end
    end

    // ----------------------------------------------------------------
    // eye scan settings and point classification
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scan_time_us_o          <= {`PGS_RST_TIME_UPPER, `PGS_RST_TIME_LOWER};
            point_window_us_o       <= {`PGS_RST_TIME_UPPER, `PGS_RST_TIME_LOWER, 1'b0};
            scan_time_valid_o       <= 1'b0;
            point_error_threshold_o <= `PGS_RST_THRESHOLD;
            eye_init_o              <= `PGS_RST_EYE_INIT;
        end
        else
        begin
            scan_time_us_o          <= scan_time;
            point_window_us_o       <= {scan_time, 1'b0};
            scan_time_valid_o       <= (scan_time >= `PGS_TIME_R1_LO && scan_time <= `PGS_TIME_R1_HI)
                                    || (scan_time >= `PGS_TIME_R2_LO && scan_time <= `PGS_TIME_R2_HI)
                                    || (scan_time >= `PGS_TIME_R3_LO && scan_time <= `PGS_TIME_R3_HI);
            point_error_threshold_o <= threshold_reg;
            eye_init_o              <= eye_init_reg;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            point_good_o         <= 1'b0;
            point_result_valid_o <= 1'b0;
        end
        else
        begin
            point_result_valid_o <= point_done_i;
            if (point_done_i)
            begin
                point_good_o <= (point_err_count_i <= threshold_reg);
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_div2_step;
        run && step_reg && (pattern_clock_divide_ratio == 2'h0);
    endsequence

    sequence s_div2_toggled;
        ##1 (div_clk_reg != $past(div_clk_reg));
    endsequence

    a_gen_off_quiet: assert property (!pattern_gen_on |=> !ser_data_o && !gen_active_o)
        else $error("output not quiet while generator off");

    a_mute_kept: assert property (auto_mute_i |=> !ser_data_o)
        else $error("auto mute overridden by generator");

    a_drive_off_kept: assert property ((auto_sleep_i || auto_disable_i) |=> !ser_drive_en_o)
        else $error("auto sleep or disable overridden by generator");

    a_clock_select: assert property ((run && !pattern_or_clock_select && !auto_mute_i)
        |=> ser_data_o == $past(div_clk_reg))
        else $error("divided clock not sent when selected");

    a_pattern_sense: assert property ((run && pattern_or_clock_select && !auto_mute_i)
        |=> ser_data_o == ($past(prbs_bit) ^ $past(pattern_invert)))
        else $error("pattern sense does not follow invert bit");

    a_reserved_src_idle: assert property ((pattern_clock_source == pgs_pkg::PGS_SRC_RSV1
        || pattern_clock_source == pgs_pkg::PGS_SRC_RSV2) |=> !gen_active_o)
        else $error("generator ran from a reserved clock source");

    a_div2_toggle: assert property (s_div2_step |-> s_div2_toggled)
        else $error("divide by two did not toggle on a step");

    a_vco_rate: assert property ((pattern_clock_source == pgs_pkg::PGS_SRC_VCO)
        |=> gen_rate_o == $past(pattern_rate_code))
        else $error("vco rate does not follow rate code");

    a_cdr_rate: assert property ((pattern_clock_source == pgs_pkg::PGS_SRC_CDR)
        |=> gen_rate_o == $past(cdr_rate_i))
        else $error("recovered clock source did not use cdr rate");

    a_locked_conflict: assert property ((pattern_gen_on && cdr_locked_i
        && pattern_clock_source == pgs_pkg::PGS_SRC_VCO && pattern_rate_code != cdr_rate_i)
        |=> rate_conflict_o && !gen_active_o)
        else $error("generator ran at a rate other than the locked rate");

    a_time_range: assert property ((scan_time > `PGS_TIME_R3_HI) |=> !scan_time_valid_o)
        else $error("scan time above range reported valid");

    a_window_double: assert property (point_window_us_o == {scan_time_us_o, 1'b0})
        else $error("point window is not twice the scan time");

    a_point_class: assert property (point_done_i |=> point_result_valid_o
        && point_good_o == ($past(point_err_count_i) <= $past(threshold_reg)))
        else $error("point classified against wrong threshold");

    a_eye_init_write: assert property ((reg_wr_i && reg_addr_i == `PGS_ADDR_EYE_CFG)
        |=> ##1 eye_init_o == $past(reg_wdata_i[`PGS_BIT_EYE_INIT], 2))
        else $error("eye init bit not taken from write");

endmodule : pgs_gen_ctrl

/* File: hw/pgs_lfsr.sv */
// stepped fibonacci lfsr producing one pattern bit per step
`timescale 1ns/1ps

module pgs_lfsr
#(
    parameter int              WIDTH = 7,
    parameter int              TAP_A = 7,
    parameter int              TAP_B = 6,
    parameter logic [WIDTH-1:0] SEED = 7'h7f
)
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic step_i,
    // pattern bit
    output logic      bit_o
);

    logic [WIDTH-1:0] state_reg;
    logic             feedback;

    assign feedback = state_reg[TAP_A-1] ^ state_reg[TAP_B-1];
    assign bit_o    = state_reg[WIDTH-1];

    // ----------------------------------------------------------------
    // shift register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= SEED;
        end
        else if (step_i)
        begin
            state_reg <= {state_reg[WIDTH-2:0], feedback};
        end
    end

    a_lfsr_nonzero: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg != '0)
        else $error("lfsr reached the all-zero lock-up state");

    a_lfsr_shift: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i |=> state_reg == {$past(state_reg[WIDTH-2:0]),
                                 $past(state_reg[TAP_A-1] ^ state_reg[TAP_B-1])})
        else $error("lfsr did not shift with the x7+x6+1 feedback");

endmodule : pgs_lfsr

/* File: hw/pgs_pkg.sv */
// types shared by the pattern generator block
package pgs_pkg;

    typedef enum logic [1:0]
    {
        PGS_SRC_VCO  = 2'h0,
        PGS_SRC_RSV1 = 2'h1,
        PGS_SRC_RSV2 = 2'h2,
        PGS_SRC_CDR  = 2'h3
    } pgs_clk_src_t;

    typedef enum logic [2:0]
    {
        PGS_RATE_RSV0 = 3'h0,
        PGS_RATE_MADI = 3'h1,
        PGS_RATE_SD   = 3'h2,
        PGS_RATE_HD   = 3'h3,
        PGS_RATE_3G   = 3'h4,
        PGS_RATE_6G   = 3'h5,
        PGS_RATE_12G  = 3'h6,
        PGS_RATE_RSV7 = 3'h7
    } pgs_rate_t;

endpackage : pgs_pkg

/* File: verif/pgs_gen_ctrl_tb.sv */
// self-checking bench of the pattern generator control block
`timescale 1ns/1ps

module pgs_gen_ctrl_tb;
    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    logic        clk_i = 1'h0, rst_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0, cdr_run = 1'h0;
    logic        cdr_locked_i = 1'h0, auto_sleep_i = 1'h0, auto_mute_i = 1'h0;
    logic        auto_disable_i = 1'h0, point_done_i = 1'h0;
    logic [7:0]  reg_addr_i = 8'h00, a;
    logic [15:0] reg_wdata_i = 16'h0000, point_err_count_i = 16'h0000;
    logic [2:0]  cdr_rate_i = 3'h6, gen_rate_o;
    logic [15:0] reg_rdata_o, point_error_threshold_o;
    logic [31:0] scan_time_us_o;
    logic [32:0] point_window_us_o;
    logic        cdr_clk_i, reg_rvalid_o, ser_data_o, ser_drive_en_o, gen_active_o, line_bit;
    logic        rate_conflict_o, scan_time_valid_o, eye_init_o, point_good_o, point_result_valid_o;
    int          mismatches = 0, samples_checked = 0, seed = 32'h6c923e10, i, j, t, c, cf, act;
    int          m [256];
    int          b [$];
    int          tv [12] = '{0, 1, 6555, 6556, 65535, 65536, 104895, 104896, 131071, 131072,
                             3350000, 3350001};

    always #25 clk_i = ~clk_i;

    pgs_gen_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .cdr_clk_i(cdr_clk_i),
        .cdr_rate_i(cdr_rate_i), .cdr_locked_i(cdr_locked_i), .auto_sleep_i(auto_sleep_i),
        .auto_mute_i(auto_mute_i), .auto_disable_i(auto_disable_i), .ser_data_o(ser_data_o),
        .ser_drive_en_o(ser_drive_en_o), .gen_active_o(gen_active_o), .gen_rate_o(gen_rate_o),
        .rate_conflict_o(rate_conflict_o), .point_done_i(point_done_i),
        .point_err_count_i(point_err_count_i), .scan_time_us_o(scan_time_us_o),
        .point_window_us_o(point_window_us_o), .scan_time_valid_o(scan_time_valid_o),
        .point_error_threshold_o(point_error_threshold_o), .eye_init_o(eye_init_o),
        .point_good_o(point_good_o), .point_result_valid_o(point_result_valid_o));

    pgs_line_model i_line (.clk_i(clk_i), .ser_data_i(ser_data_o), .drive_en_i(ser_drive_en_o),
        .cdr_run_i(cdr_run), .cdr_clk_o(cdr_clk_i), .line_o(line_bit));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic settle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i  <= ad;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
        if (ad == 8'h52)
            m[ad] = d & 16'h03ff;
        else if (ad == 8'h57)
            m[ad] = d & 16'h0004;
        else if (ad inside {8'h54, 8'h55, 8'h56})
            m[ad] = d;
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_rd_i   <= 1'h1;
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
        #1;
        chk("rvalid", reg_rvalid_o, 1);
        chk("rdata", reg_rdata_o, m[ad]);
    endtask : rd

    task automatic pt(input logic [15:0] cnt);
        int n;
        @(posedge clk_i);
        point_done_i      <= 1'h1;
        point_err_count_i <= cnt;
        @(posedge clk_i);
        point_done_i <= 1'h0;
        #1;
        for (n = 0; n < 4 && point_result_valid_o !== 1'h1; n++)
        begin
            @(posedge clk_i);
            #1;
        end
        if (n == 4)
        begin
            mismatches++;
            final_report();
        end
        chk("pvalid", point_result_valid_o, 1);
        chk("good", point_good_o, cnt <= m[8'h56]);
    endtask : pt

    task automatic grab(input int n);
        b = {};
        repeat (n)
        begin
            @(posedge clk_i);
            #1;
            b.push_back(int'(line_bit));
        end
    endtask : grab

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        m = '{default: 0};
        m[8'h52] = 32'h0106;
        m[8'h55] = 32'h0064;
        m[8'h56] = 32'h0064;
        repeat (5) @(posedge clk_i);
        rst_i   <= 1'h0;
        cdr_run <= 1'h1;
        for (i = 8'h52; i < 8'h59; i++)
            rd(8'(i));
        for (i = 0; i < 12; i++)
        begin
            a = 8'h52 + 8'($unsigned($random(seed)) % 7);
            wr(a, 16'($random(seed)));
            rd(a);
        end
        wr(8'h57, 16'h0004);
        settle();
        chk("init", eye_init_o, m[8'h57] >> 2);
        wr(8'h56, 16'h0064);
        settle();
        chk("thr", point_error_threshold_o, 16'h0064);
        pt(16'h0064);
        pt(16'h0065);
        pt(16'($random(seed)));
        foreach (tv[k])
        begin
            wr(8'h54, 16'(tv[k] >> 16));
            wr(8'h55, 16'(tv[k]));
            settle();
            chk("time", scan_time_us_o, tv[k]);
            chk("window", point_window_us_o, 2 * tv[k]);
            chk("tvalid", scan_time_valid_o, tv[k] inside {[1:6555], [65536:104895],
                [131072:3350000]});
        end
        for (i = 0; i < 32; i++)
        begin
            @(posedge clk_i);
            c = $unsigned($random(seed)) % 6 + 1;
            cdr_rate_i   <= 3'(c);
            cdr_locked_i <= 1'($random(seed));
            wr(8'h52, 16'h0300 | 16'((i & 24) << 3) | 16'(i & 7));
            settle();
            cf  = cdr_locked_i && i < 8 && (i & 7) != c;
            act = i < 8 ? (i & 7) inside {[1:6]} && !cf : i >= 24;
            chk("conflict", rate_conflict_o, cf);
            chk("active", gen_active_o, act);
            if (act)
                chk("rate", gen_rate_o, i >= 24 ? c : i & 7);
        end
        cdr_locked_i <= 1'h0;
        for (i = 0; i < 12; i++)
        begin
            wr(8'h52, 16'h0208 | 16'((i & 3) << 4) | 16'(4 + i / 4));
            settle();
            grab(130);
            t = -1;
            for (j = 1; j < 130; j++)
                if (b[j] != b[j-1])
                begin
                    if (t >= 0)
                        chk("div", j - t, 1 << ((i & 3) + 2 - i / 4));
                    t = j;
                end
        end
        for (i = 0; i < 2; i++)
        begin
            wr(8'h52, 16'h0306 | 16'(i << 3));
            settle();
            grab(140);
            chk("live", b.sum() > 0, 1);
            for (j = 7; j < 140; j++)
                chk("prbs", b[j], b[j-7] ^ b[j-6] ^ i);
            for (j = 127; j < 140; j++)
                chk("period", b[j], b[j-127]);
        end
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            auto_sleep_i   <= i[0];
            auto_mute_i    <= i[1];
            auto_disable_i <= i[2];
            settle();
            chk("drive", ser_drive_en_o, !(i[0] | i[2]));
            chk("on", gen_active_o, 1);
            if (i[1])
                chk("mute", ser_data_o, 0);
        end
        @(posedge clk_i);
        {auto_sleep_i, auto_mute_i, auto_disable_i} <= 3'h0;
        wr(8'h52, 16'h0106);
        settle();
        chk("off", gen_active_o, 0);
        chk("offdata", ser_data_o, 0);
        final_report();
    end
endmodule : pgs_gen_ctrl_tb

/* File: verif/pgs_line_model.sv */
// behavioural far side: recovered clock source and the driven serial line
`timescale 1ns/1ps

module pgs_line_model
(
    // clock
    input  wire logic clk_i,
    // serial line from the block and receiver run enable
    input  wire logic ser_data_i,
    input  wire logic drive_en_i,
    input  wire logic cdr_run_i,
    // recovered clock and line level
    output logic      cdr_clk_o,
    output logic      line_o
);
    logic last_bit = 1'h0;
    initial cdr_clk_o = 1'h0;
    // recovered clock stands still unless the receiver runs
    always #37 cdr_clk_o = cdr_run_i & ~cdr_clk_o;
    // an undriven line shows the inverse of the last driven bit
    always @(posedge clk_i)
        if (drive_en_i)
            last_bit <= ser_data_i;
    assign line_o = drive_en_i ? ser_data_i : ~last_bit;
endmodule : pgs_line_model
